/* logic/analog_input_bus_interface.v */
// Contract
// - With enable checking on and no enable voltage, no bus access is acknowledged.
// - Jumper inserted makes enable checking active; jumper open ignores enable input.
// - Base address comes from a six-bit switch (the code drops switch bit 5); every bus address answers, unmapped ones with an error.
// - Each input is integrated over its measurement period to suppress interference.
// - Mode switches enable broken-wire checking on four or eight inputs.
// - Before each encoding of a checked input a 1.6 ms test pulse runs and is limit checked.
// - A broken wire sets bit 1 of byte 1 and stores value zero.
// - Test pulses stop when inhibit is asserted and checking is switched off.
// - Over-range sets the overflow flag in bit 0 of the low byte.
// - Cyclic mode converts all channels; high byte first, low byte next.
// - In cyclic mode any base address 0 through 255 is accepted.
// - In selective mode one host write starts exactly one conversion.
// - Conversion-active flag is 1 during selective conversion, 0 once valid.
// - In selective mode the base address lies between 128 and 255.
// - Channel address is 0x040 plus four times the channel number.
`timescale 1ns/1ns
`include "ain_defs.vh"
module analog_input_bus_interface #(
  parameter NCH       = 8,
  parameter W         = 12,
  parameter PULSE_CYC = `WIRE_PULSE_CYC,
  parameter INTEG_CYC = `INTEG_CYC
) (
  // Clock and reset.
  input  wire        REF_CLK,
  input  wire        SYS_RST,
  // AXI4-Lite write address and data.
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  // AXI4-Lite write response.
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // AXI4-Lite read.
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // Module straps and pins.
  input  wire [5:0]  ADDRESS_SWITCH_BIT,
  input  wire        ENABLE_JUMPER,
  input  wire        ENABLE_VOLTAGE,
  input  wire        PULSE_INHIBIT,
  // Converter front end.
  input  wire [W-1:0] ADC_SAMPLE,
  input  wire         ADC_OVER,
  input  wire [W-1:0] WIRE_LEVEL,
  input  wire [W-1:0] WIRE_LIMIT,
  output reg  [2:0]   CHAN_SELECT,
  output reg          TEST_CURRENT,
  // Interrupt.
  output reg          IRQ
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WIRE = 2'h1;
  localparam [1:0] S_CONV = 2'h2;

  reg [3:0]    ctrl_r;
  reg [3:0]    irq_stat_r;
  reg [3:0]    irq_mask_r;
  reg [15:0]   data_r [0:NCH-1];
  reg [1:0]    state_r;
  reg [2:0]    ch_r;
  reg          active_r;
  reg          valid_r;
  reg          start_r;
  reg          sel_req_r;
  reg [2:0]    sel_ch_r;
  reg          aw_got_r;
  reg          w_got_r;
  reg [11:0]   awaddr_r;
  reg [31:0]   wdata_r;
  reg [3:0]    wstrb_r;
  reg [3:0]    irq_set;
  wire         wt_done;
  wire         wt_broken;
  wire         wt_pulse;
  wire         int_done;
  wire [W-1:0] int_result;
  wire         wt_start;
  wire         int_start;
  wire         wire_en;
  wire         enabled;
  wire [7:0]   base;
  wire         base_ok;
  wire [3:0]   aw_chan;
  wire [3:0]   ar_chan;

  // Decodes a byte-address into a channel word, or flags it as outside.
  function [3:0] chan_of;
    input [11:0] a;
    begin
      if (a >= `OFF_CHAN_BASE && a < `OFF_CHAN_BASE + 12'h004 * NCH[11:0])
        chan_of = {1'b1, a[4:2]};
      else
        chan_of = 4'h0;
    end
  endfunction

  assign enabled = !ENABLE_JUMPER || ENABLE_VOLTAGE;
  assign base    = {ADDRESS_SWITCH_BIT, 2'h0} << 1;
  assign base_ok = !ctrl_r[`CTRL_SELECTIVE] || (base >= `SEL_MIN_BASE);
  assign wire_en = ctrl_r[`CTRL_WIRE_EN] && (ctrl_r[`CTRL_WIRE8] || !ch_r[2]) &&
                   !(PULSE_INHIBIT && !ctrl_r[`CTRL_WIRE_EN]);
  assign wt_start  = start_r;
  assign aw_chan   = chan_of(awaddr_r);
  assign ar_chan   = chan_of(S_AXI_ARADDR);
  assign int_start = wt_done;

  ain_wire_test #(.W(W), .CNT_W(32)) u_wire (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .start     (wt_start),
    .enable    (wire_en),
    .pulse_cyc (PULSE_CYC),
    .level     (WIRE_LEVEL),
    .limit     (WIRE_LIMIT),
    .pulse     (wt_pulse),
    .done      (wt_done),
    .broken    (wt_broken)
  );

  ain_integrator #(.W(W), .PER_W(32)) u_int (
    .clk    (REF_CLK),
    .rst    (SYS_RST),
    .start  (int_start),
    .period (INTEG_CYC),
    .sample (ADC_SAMPLE),
    .done   (int_done),
    .result (int_result)
  );

  // Conversion sequencer.
  integer i;
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r      <= S_IDLE;
      ch_r         <= 3'h0;
      active_r     <= 1'b0;
      valid_r      <= 1'b0;
      start_r      <= 1'b0;
      CHAN_SELECT  <= 3'h0;
      TEST_CURRENT <= 1'b0;
      for (i = 0; i < NCH; i = i + 1)
        data_r[i] <= 16'h0000;
    end else begin
      start_r      <= 1'b0;
      TEST_CURRENT <= wt_pulse;
      CHAN_SELECT  <= ch_r;
      case (state_r)
        S_IDLE: begin
          if (!ctrl_r[`CTRL_SELECTIVE] && base_ok) begin
            start_r <= 1'b1;
            state_r <= S_WIRE;
          end else if (sel_req_r && base_ok) begin
            start_r  <= 1'b1;
            ch_r     <= sel_ch_r;
            active_r <= 1'b1;
            state_r  <= S_WIRE;
          end
        end
        S_WIRE: begin
          if (wt_done)
            state_r <= S_CONV;
        end
        S_CONV: begin
          if (int_done) begin
            if (wt_broken)
              data_r[ch_r] <= 16'h0002;
            else
              data_r[ch_r] <= {int_result, 3'h0, ADC_OVER};
            active_r <= 1'b0;
            valid_r  <= 1'b1;
            if (!ctrl_r[`CTRL_SELECTIVE])
              ch_r <= (ch_r == NCH[2:0] - 3'h1) ? 3'h0 : ch_r + 3'h1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Interrupt events.
  always @* begin
    irq_set = 4'h0;
    irq_set[`IRQ_DONE]   = state_r == S_CONV && int_done;
    irq_set[`IRQ_WIRE]   = state_r == S_CONV && int_done && wt_broken;
    irq_set[`IRQ_OVER]   = state_r == S_CONV && int_done && ADC_OVER;
    irq_set[`IRQ_REFUSE] = (S_AXI_ARVALID || S_AXI_AWVALID) && !enabled;
  end

  // AXI4-Lite slave.
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RRESP   <= 2'h0;
      S_AXI_RDATA   <= 32'h00000000;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `CTRL_RESET;
      irq_mask_r    <= 4'h0;
      irq_stat_r    <= 4'h0;
      sel_req_r     <= 1'b0;
      sel_ch_r      <= 3'h0;
      IRQ           <= 1'b0;
    end else begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
      if (state_r == S_IDLE && sel_req_r && base_ok)
        sel_req_r <= 1'b0;
      if (S_AXI_AWVALID && !S_AXI_AWREADY && !aw_got_r && enabled) begin
        S_AXI_AWREADY <= 1'b1;
        aw_got_r      <= 1'b1;
        awaddr_r      <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !S_AXI_WREADY && !w_got_r && enabled) begin
        S_AXI_WREADY <= 1'b1;
        w_got_r      <= 1'b1;
        wdata_r      <= S_AXI_WDATA;
        wstrb_r      <= S_AXI_WSTRB;
      end
      irq_stat_r <= irq_stat_r | irq_set;
      if (aw_got_r && w_got_r && !S_AXI_BVALID) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= 2'h0;
        if (awaddr_r == `OFF_CTRL && wstrb_r[0])
          ctrl_r <= wdata_r[3:0];
        else if (awaddr_r == `OFF_IRQ_MASK && wstrb_r[0])
          irq_mask_r <= wdata_r[3:0];
        else if (awaddr_r == `OFF_IRQ_STAT && wstrb_r[0])
          irq_stat_r <= (irq_stat_r & ~wdata_r[3:0]) | irq_set;
        else if (awaddr_r == `OFF_SAMPLE && ctrl_r[`CTRL_SELECTIVE]) begin
          sel_req_r <= 1'b1;
          sel_ch_r  <= wdata_r[2:0];
        end else if (awaddr_r != `OFF_STATUS && awaddr_r != `OFF_BUS &&
                 !aw_chan[3])
          S_AXI_BRESP <= 2'h2;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID && enabled) begin
        S_AXI_ARREADY <= 1'b1;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= 2'h0;
        S_AXI_RDATA   <= 32'h00000000;
        if (ar_chan[3])
          S_AXI_RDATA <= {16'h0000, data_r[ar_chan[2:0]]};
        else if (S_AXI_ARADDR == `OFF_CTRL)
          S_AXI_RDATA <= {28'h0000000, ctrl_r};
        else if (S_AXI_ARADDR == `OFF_STATUS)
          S_AXI_RDATA <= {29'h0000000, enabled, valid_r, active_r};
        else if (S_AXI_ARADDR == `OFF_IRQ_STAT)
          S_AXI_RDATA <= {28'h0000000, irq_stat_r};
        else if (S_AXI_ARADDR == `OFF_IRQ_MASK)
          S_AXI_RDATA <= {28'h0000000, irq_mask_r};
        else if (S_AXI_ARADDR == `OFF_BUS)
          S_AXI_RDATA <= {16'h0000, base + 8'h00, 2'h0, ADDRESS_SWITCH_BIT};
        else if (S_AXI_ARADDR != `OFF_SAMPLE)
          S_AXI_RRESP <= 2'h2;
      end
      if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      IRQ <= |((irq_stat_r | irq_set) & irq_mask_r);
    end
  end
endmodule

/* inc/ain_defs.vh */
`ifndef AIN_DEFS_VH
`define AIN_DEFS_VH

// AXI4-Lite register byte offsets.
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_IRQ_STAT  12'h008
`define OFF_IRQ_MASK  12'h00c
`define OFF_SAMPLE    12'h010
`define OFF_BUS       12'h014
`define OFF_CHAN_BASE 12'h040

// Control register fields.
`define CTRL_SELECTIVE 0
`define CTRL_START     1
`define CTRL_WIRE8     2
`define CTRL_WIRE_EN   3
`define CTRL_RESET     4'h0

// Status register fields.
`define ST_ACTIVE 0
`define ST_VALID  1
`define ST_ENABLE 2

// Interrupt status fields.
`define IRQ_DONE   0
`define IRQ_WIRE   1
`define IRQ_OVER   2
`define IRQ_REFUSE 3

// Data byte flags.
`define FLAG_OVER 0
`define FLAG_WIRE 1

// Timing.
`define CLK_MHZ          100
`define WIRE_PULSE_US    1600
`define WIRE_PULSE_CYC   (`WIRE_PULSE_US * `CLK_MHZ)
`define INTEG_US         200
`define INTEG_CYC        (`INTEG_US * `CLK_MHZ)

// Address windows.
`define SEL_MIN_BASE 8'h80

`endif

/* logic/ain_integrator.v */
`timescale 1ns/1ns
`include "ain_defs.vh"
// Accumulates samples over a measurement period and reports the mean.
module ain_integrator #(
  parameter W     = 12,
  parameter PER_W = 16
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst,
  // Control.
  input  wire             start,
  input  wire [PER_W-1:0] period,
  input  wire [W-1:0]     sample,
  // Result.
  output reg              done,
  output reg  [W-1:0]     result
);
  reg [PER_W-1:0]   cnt_r;
  reg [W+PER_W-1:0] acc_r;
  reg               busy_r;
  wire [W+PER_W-1:0] acc_nxt;
  wire [W+PER_W-1:0] mean;

  // The last sample joins the sum before it is divided by the sample count.
  assign acc_nxt = acc_r + {{PER_W{1'b0}}, sample};
  assign mean    = acc_nxt / {{W{1'b0}}, period};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= {PER_W{1'b0}};
      acc_r  <= {(W+PER_W){1'b0}};
      busy_r <= 1'b0;
      done   <= 1'b0;
      result <= {W{1'b0}};
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        cnt_r  <= period;
        acc_r  <= {(W+PER_W){1'b0}};
      end else if (busy_r) begin
        acc_r <= acc_nxt;
        if (cnt_r == {{(PER_W-1){1'b0}}, 1'b1}) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
          result <= mean[W-1:0];
        end else begin
          cnt_r <= cnt_r - {{(PER_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* logic/ain_wire_test.v */
`timescale 1ns/1ns
`include "ain_defs.vh"
// Applies the broken-wire test current and checks the level against a limit.
module ain_wire_test #(
  parameter W     = 12,
  parameter CNT_W = 18
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst,
  // Control.
  input  wire             start,
  input  wire             enable,
  input  wire [CNT_W-1:0] pulse_cyc,
  input  wire [W-1:0]     level,
  input  wire [W-1:0]     limit,
  // Result.
  output reg              pulse,
  output reg              done,
  output reg              broken
);
  reg [CNT_W-1:0] cnt_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= {CNT_W{1'b0}};
      pulse  <= 1'b0;
      done   <= 1'b0;
      broken <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        if (enable) begin
          pulse <= 1'b1;
          cnt_r <= pulse_cyc;
        end else begin
          done   <= 1'b1;
          broken <= 1'b0;
        end
      end else if (pulse) begin
        if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          pulse  <= 1'b0;
          done   <= 1'b1;
          broken <= (level > limit);
        end else begin
          cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* sim/ain_front_model.sv */
`timescale 1ns/1ns
module ain_front_model (
  input  wire logic [2:0]  chan,
  input  wire logic        test,
  input  wire logic [11:0] base,
  input  wire logic [7:0]  brk,
  input  wire logic [7:0]  ovr,
  output logic      [11:0] sample,
  output logic             over,
  output logic      [11:0] level
);
  // Each channel holds a steady level; a broken line reads full scale under test current.
  always_comb begin
    sample = base ^ {chan, chan, chan, chan};
    over   = ovr[chan];
    level  = test ? (brk[chan] ? 12'hfff : 12'h001) : 12'h800;
  end
endmodule

/* sim/analog_input_bus_interface_asserts.sv */
`timescale 1ns/1ns
module ain_bus_checker #(
  parameter PULSE_CYC = 4
) (
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        ENABLE_JUMPER,
  input wire logic        ENABLE_VOLTAGE,
  input wire logic [2:0]  CHAN_SELECT,
  input wire logic        TEST_CURRENT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  logic [31:0] pcnt_r;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) pcnt_r <= 32'h0;
    else pcnt_r <= TEST_CURRENT ? pcnt_r + 32'h1 : 32'h0;
  end
  a_refuse_access: assert property (ENABLE_JUMPER && !ENABLE_VOLTAGE &&
    $past(ENABLE_JUMPER && !ENABLE_VOLTAGE) |-> !S_AXI_ARREADY && !S_AXI_AWREADY)
    else $error("access answered while switched off");
  a_jumper_open: assert property (!ENABLE_JUMPER && S_AXI_ARVALID &&
    !S_AXI_ARREADY && !S_AXI_RVALID |=> S_AXI_ARREADY && S_AXI_RVALID)
    else $error("read not answered with jumper open");
  a_unmapped_resp: assert property (!ENABLE_JUMPER && S_AXI_ARVALID &&
    !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARADDR == 12'hffc |=> S_AXI_RRESP == 2'h2)
    else $error("unmapped read not refused");
  a_pulse_length: assert property ($fell(TEST_CURRENT) |-> pcnt_r == PULSE_CYC)
    else $error("test pulse length wrong");
  a_pulse_channel: assert property (TEST_CURRENT && $past(TEST_CURRENT)
    |-> $stable(CHAN_SELECT)) else $error("channel moved during test pulse");
  a_read_single: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data repeated");
  a_write_resp: assert property ($rose(S_AXI_BVALID) |-> $past(S_AXI_WREADY))
    else $error("write response without data");
  a_bresp_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
endmodule
bind analog_input_bus_interface ain_bus_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (.*);

/* sim/tb_analog_input_bus_interface.sv */
`timescale 1ns/1ns
`include "ain_defs.vh"
module tb_analog_input_bus_interface;
  logic clk, rst, awv, awr, wv, wr_r, bv, brdy, arv, arr, rv, rrdy, jmp, volt, inh, irq, tc, ov;
  logic [11:0] awa, ara, base, smp, lvl, lim;
  logic [31:0] wd, rdat, d, old, seed;
  logic [1:0]  rresp;
  logic [5:0]  sw;
  logic [7:0]  brk, ovr;
  logic [2:0]  chs;
  int miscompares, tests_run, waited, n, k, ch, nw;
  analog_input_bus_interface #(.NCH(8), .W(12), .PULSE_CYC(4), .INTEG_CYC(8)) i_dut (
    .REF_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_r), .S_AXI_BRESP(), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .ADDRESS_SWITCH_BIT(sw),
    .ENABLE_JUMPER(jmp), .ENABLE_VOLTAGE(volt), .PULSE_INHIBIT(inh), .ADC_SAMPLE(smp),
    .ADC_OVER(ov), .WIRE_LEVEL(lvl), .WIRE_LIMIT(lim), .CHAN_SELECT(chs),
    .TEST_CURRENT(tc), .IRQ(irq));
  ain_front_model i_model (.chan(chs), .test(tc), .base(base), .brk(brk), .ovr(ovr),
    .sample(smp), .over(ov), .level(lvl));
  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_w(input int c, input int nb);
    logic [2:0] q;
    q = c[2:0];
    if (c < nb && brk[c]) return 32'h2;
    return {16'h0, base ^ {q, q, q, q}, 3'h0, ovr[c]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrt(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    brdy <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1; waited = 0;
    do begin
      @(posedge clk);
      waited++;
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rdat; rrdy <= 1'b0;
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    {rst, awv, wv, brdy, arv, rrdy, jmp, inh} = 8'hff; {awv, wv, brdy, arv, rrdy, jmp, inh} = 0;
    volt = 1; awa = 0; ara = 0; wd = 0; sw = 6'h14; brk = 0; ovr = 0; seed = 32'hb4e1b112;
    base = 0; miscompares = 0; tests_run = 0; lim = 12'h800;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`OFF_CTRL, d); chk(d, 32'h0);
    for (k = 0; k < 3; k++) begin
      seed = lf(seed); base <= seed[11:0]; ovr <= seed[19:12]; sw <= seed[25:20];
      repeat (600) @(posedge clk);
      for (ch = 0; ch < 8; ch++) begin
        rd(`OFF_CHAN_BASE + 4 * ch, d); chk(d, exp_w(ch, 0));
      end
    end
    brk <= 8'hff;
    for (nw = 4; nw <= 8; nw += 4) begin
      wrt(`OFF_CTRL, (32'h1 << `CTRL_WIRE_EN) | (nw == 8 ? 32'h1 << `CTRL_WIRE8 : 32'h0));
      repeat (600) @(posedge clk);
      for (ch = 0; ch < 8; ch++) begin
        rd(`OFF_CHAN_BASE + 4 * ch, d); chk(d, exp_w(ch, nw));
      end
    end
    wrt(`OFF_CTRL, 32'h0); inh <= 1'b1; brk <= 0; ovr <= 0; n = 0;
    repeat (10) @(posedge clk);
    repeat (300) @(posedge clk) n += tc;
    chk(n, 0);
    inh <= 1'b0; sw <= 6'h14;
    wrt(`OFF_CTRL, 32'h1 << `CTRL_SELECTIVE); wrt(`OFF_IRQ_MASK, 0);
    repeat (300) @(posedge clk);
    wrt(`OFF_IRQ_STAT, 32'hf); old = exp_w(0, 0); seed = lf(seed); base <= seed[11:0];
    wrt(`OFF_SAMPLE, 32'h0);
    rd(`OFF_STATUS, d); chk(d[`ST_ACTIVE], 1);
    rd(`OFF_CHAN_BASE, d); chk(d, old);
    n = 0;
    do begin rd(`OFF_STATUS, d); n++; end while (d[`ST_ACTIVE] && n < 100);
    chk(d[1:0], 32'h2);
    rd(`OFF_CHAN_BASE, d); chk(d, exp_w(0, 0));
    chk(irq, 0);
    wrt(`OFF_IRQ_MASK, 32'h1); repeat (2) @(posedge clk); chk(irq, 1);
    wrt(`OFF_IRQ_STAT, 32'h1); repeat (2) @(posedge clk); chk(irq, 0);
    repeat (200) @(posedge clk);
    rd(`OFF_STATUS, d); chk(d[`ST_ACTIVE], 0);
    sw <= 6'h01; wrt(`OFF_SAMPLE, 32'h1);
    rd(`OFF_STATUS, d); chk(d[`ST_ACTIVE], 0);
    rd(12'hffc, d); chk(rresp, 32'h2);
    jmp <= 1'b1; volt <= 1'b0;
    fork
      rd(`OFF_STATUS, d);
      begin repeat (30) @(posedge clk); volt <= 1'b1; end
    join
    chk(waited >= 30, 1);
    rd(`OFF_IRQ_STAT, d); chk(d[`IRQ_REFUSE], 1);
    jmp <= 1'b0; volt <= 1'b0;
    rd(`OFF_CTRL, d); chk(waited, 2);
    finish_test;
  end
endmodule
